// [common/oxr_params.svh]
// Purpose: constants of the auxiliary RAM decode and its register block
// Assumes: included by the design file; the guard stops a second copy
// Notes: register offsets are indices; byte address is four times the index
`ifndef OXR_PARAMS_SVH
`define OXR_PARAMS_SVH
`define OXR_RAM_DEPTH 1024
`define OXR_RAM_TOP 16'h03ff
`define OXR_IDX_CHIP_CONTROL 8'h9f
`define OXR_IDX_RAM_PAGE_HIGH 8'ha1
`define OXR_IDX_TIMED_ACCESS 8'hc7
`define OXR_IDX_PORT_ZERO 8'h80
`define OXR_IDX_PORT_TWO 8'ha0
`define OXR_ENABLE_BIT 4
`define OXR_CHIP_CONTROL_RST 8'h10
`define OXR_CHIP_CONTROL_WMASK 8'h73
`define OXR_PAGE_MASK 8'h03
`define OXR_PORT_RST 8'hff
`define OXR_TA_KEY_ONE 8'haa
`define OXR_TA_KEY_TWO 8'h55
`define OXR_TA_WINDOW 3'h4
`define OXR_STROBE_CYC 3'h4
`endif

// [common/oxr_pkg.sv]
// Purpose: shared types of the auxiliary RAM decode block
// Assumes: nothing beyond the params header
// Notes: one request per external move or external code read
package oxr_pkg;
   typedef enum logic [1:0] {
      OXR_OP_DATA_POINTER,
      OXR_OP_INDEX,
      OXR_OP_CODE
   } oxr_op_t;
   typedef struct packed {
      oxr_op_t op;
      logic write;
      logic stack;
      logic [15:0] data_pointer;
      logic [7:0] index;
      logic [7:0] wdata;
   } oxr_req_t;
   typedef struct packed {
      logic ale;
      logic rd_n;
      logic wr_n;
      logic [7:0] p0_out;
      logic [7:0] p0_oe;
      logic [7:0] p2_out;
      logic [7:0] p2_oe;
   } oxr_pins_t;
endpackage

// [src/oxr_auxiliary_ram_decode.sv]
// Purpose: on-chip 1 KB auxiliary RAM with external-move decode and bus cycles
// Assumes: core holds one request until o_req_ready, single 50 MHz clock
// Notes: port zero pin levels pass two flip-flops before the read sample
// Behaviour
// - On-chip RAM covers external data addresses 0 through 3FFH.
// - Every reset sets the on-chip RAM enable bit to one.
// - Enable bit four of chip control: zero off chip, one on chip.
// - All 1024 bytes reachable by pointer or page-extended index moves.
// - Enabled: non-stack indexed moves always hit RAM, never make bus cycles.
// - Pointer moves above 3FFH always go to the external bus.
// - Chip control writes accepted only after the timed-access unlock.
// - RAM accesses leave ports, read and write strobes inactive.
// - Stack accesses never touch the auxiliary RAM.
// - Page register bits 1:0 give address 9:8; reset zero.
// - Bus cycles drive ports zero and two strongly both ways.
// - Port zero carries low address byte then data byte.
// - During external code execution port latches are locked.
// - Port two carries the upper address byte in bus cycles.
//
// The Avalon-MM interface to the registers was decided locally.
`timescale 1ns/10ps
`default_nettype none
`include "oxr_params.svh"
module oxr_auxiliary_ram_decode
   import oxr_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_req_valid,
   input wire oxr_req_t i_req,
   output logic o_req_ready,
   output logic o_done,
   output logic [7:0] o_rdata,
   input wire logic i_ext_code_exec,
   input wire logic [7:0] i_p0_in,
   output var oxr_pins_t o_pins,
   input wire logic [9:0] i_avs_address,
   input wire logic i_avs_read,
   input wire logic i_avs_write,
   input wire logic [31:0] i_avs_writedata,
   output logic [31:0] o_avs_readdata,
   output logic o_avs_waitrequest
);
   typedef enum logic [1:0] {IDLE, EXT_ADDR, EXT_STROBE} oxr_state_t;

   // Word index taken from the byte address
   function automatic logic [7:0] oxr_index(input logic [9:0] addr);
      oxr_index = addr[9:2];
   endfunction

   logic [7:0] ram_q [0:`OXR_RAM_DEPTH-1];
   oxr_state_t state_q, state_d;
   logic [7:0] chip_control_q, chip_control_d;
   logic [7:0] page_q, page_d;
   logic [7:0] p0_latch_q, p0_latch_d;
   logic [7:0] p2_latch_q, p2_latch_d;
   logic ta_armed_q, ta_armed_d;
   logic [2:0] ta_win_q, ta_win_d;
   logic [2:0] cnt_q, cnt_d;
   logic [15:0] addr_q, addr_d;
   logic [7:0] wdata_q, wdata_d;
   logic write_q, write_d;
   logic done_q, done_d;
   logic [7:0] rdata_q, rdata_d;
   logic rack_q, rack_d;
   logic [31:0] avs_rd_q, avs_rd_d;
   logic [7:0] p0_meta_q, p0_sync_q;
   logic enable;
   logic [15:0] req_addr;
   logic ram_hit;
   logic accept;
   logic ram_we;
   logic [9:0] ram_addr;
   logic [7:0] wr_byte;
   logic [7:0] rd_idx;

   ////////////////////////////////////////////////////////////////////////////
   // Address decode of the pending request
   assign enable = chip_control_q[`OXR_ENABLE_BIT];
   assign o_req_ready = (state_q == IDLE) && !done_q;
   assign accept = i_req_valid && o_req_ready;
   assign wr_byte = i_avs_writedata[7:0];
   assign rd_idx = oxr_index(i_avs_address);
   always_comb begin
      req_addr = i_req.data_pointer;
      ram_hit = 1'b0;
      if (i_req.op == OXR_OP_INDEX) begin
         req_addr = {p2_latch_q, i_req.index};
         // Page bits extend the index inside the RAM
         if (enable) begin
            req_addr = {6'h00, page_q[1:0], i_req.index};
         end
         ram_hit = enable;
      end else if (i_req.op == OXR_OP_DATA_POINTER) begin
         ram_hit = enable && (i_req.data_pointer <= `OXR_RAM_TOP);
      end
      if (i_req.stack) begin
         ram_hit = 1'b0;
      end
   end
   assign ram_addr = req_addr[9:0];
   assign ram_we = accept && ram_hit && i_req.write;

   ////////////////////////////////////////////////////////////////////////////
   // Pin input synchroniser; only the second stage is looked at
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         p0_meta_q <= 8'h00;
         p0_sync_q <= 8'h00;
      end else begin
         p0_meta_q <= i_p0_in;
         p0_sync_q <= p0_meta_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // RAM array; no reset, content survives by design
   always_ff @(posedge i_clk) begin
      if (ram_we) begin
         ram_q[ram_addr] <= i_req.wdata;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Move sequencer: one-cycle RAM answer or a bus cycle
   always_comb begin
      state_d = state_q;
      cnt_d = cnt_q;
      addr_d = addr_q;
      wdata_d = wdata_q;
      write_d = write_q;
      done_d = 1'b0;
      rdata_d = rdata_q;
      unique case (state_q)
         IDLE: begin
            if (accept && ram_hit) begin
               done_d = 1'b1;
               if (!i_req.write) begin
                  rdata_d = ram_q[ram_addr];
               end
            end else if (accept) begin
               state_d = EXT_ADDR;
               addr_d = req_addr;
               wdata_d = i_req.wdata;
               write_d = i_req.write && (i_req.op != OXR_OP_CODE);
            end
         end
         EXT_ADDR: begin
            state_d = EXT_STROBE;
            cnt_d = `OXR_STROBE_CYC;
         end
         EXT_STROBE: begin
            cnt_d = cnt_q - 3'h1;
            // Late sample covers the two-stage input delay
            if (cnt_q == 3'h1) begin
               state_d = IDLE;
               done_d = 1'b1;
               if (!write_q) begin
                  rdata_d = p0_sync_q;
               end
            end
         end
      endcase
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         state_q <= IDLE;
         cnt_q <= 3'h0;
         addr_q <= 16'h0000;
         wdata_q <= 8'h00;
         write_q <= 1'b0;
         done_q <= 1'b0;
         rdata_q <= 8'h00;
      end else begin
         state_q <= state_d;
         cnt_q <= cnt_d;
         addr_q <= addr_d;
         wdata_q <= wdata_d;
         write_q <= write_d;
         done_q <= done_d;
         rdata_q <= rdata_d;
      end
   end
   assign o_done = done_q;
   assign o_rdata = rdata_q;

   ////////////////////////////////////////////////////////////////////////////
   // Pins: bus cycles drive both levels, idle ports act as open-drain latches
   always_comb begin
      o_pins.ale = 1'b0;
      o_pins.rd_n = 1'b1;
      o_pins.wr_n = 1'b1;
      o_pins.p0_out = p0_latch_q;
      o_pins.p0_oe = ~p0_latch_q;
      o_pins.p2_out = p2_latch_q;
      o_pins.p2_oe = ~p2_latch_q;
      if (state_q == EXT_ADDR) begin
         o_pins.ale = 1'b1;
         o_pins.p0_out = addr_q[7:0];
         o_pins.p0_oe = 8'hff;
      end else if (state_q == EXT_STROBE) begin
         o_pins.rd_n = write_q;
         o_pins.wr_n = !write_q;
         o_pins.p0_out = wdata_q;
         o_pins.p0_oe = {8{write_q}};
      end
      if (state_q != IDLE) begin
         o_pins.p2_out = addr_q[15:8];
         o_pins.p2_oe = 8'hff;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Register slave; reads answer one cycle late, writes at once
   assign o_avs_waitrequest = i_avs_read && !rack_q;
   assign o_avs_readdata = avs_rd_q;
   always_comb begin
      chip_control_d = chip_control_q;
      page_d = page_q;
      p0_latch_d = p0_latch_q;
      p2_latch_d = p2_latch_q;
      ta_armed_d = 1'b0;
      ta_win_d = (ta_win_q != 3'h0) ? ta_win_q - 3'h1 : 3'h0;
      rack_d = i_avs_read && !rack_q;
      avs_rd_d = 32'h0000_0000;
      if (i_avs_write) begin
         if (rd_idx == `OXR_IDX_TIMED_ACCESS) begin
            ta_armed_d = (wr_byte == `OXR_TA_KEY_ONE);
            if (ta_armed_q && (wr_byte == `OXR_TA_KEY_TWO)) begin
               ta_win_d = `OXR_TA_WINDOW;
            end
         end
         if ((rd_idx == `OXR_IDX_CHIP_CONTROL) && (ta_win_q != 3'h0)) begin
            chip_control_d = wr_byte & `OXR_CHIP_CONTROL_WMASK;
            ta_win_d = 3'h0;
         end
         if (rd_idx == `OXR_IDX_RAM_PAGE_HIGH) begin
            page_d = wr_byte & `OXR_PAGE_MASK;
         end
         // Latches frozen while code runs from the external bus
         if ((rd_idx == `OXR_IDX_PORT_ZERO) && !i_ext_code_exec) begin
            p0_latch_d = wr_byte;
         end
         if ((rd_idx == `OXR_IDX_PORT_TWO) && !i_ext_code_exec) begin
            p2_latch_d = wr_byte;
         end
      end
      if (i_avs_read && !rack_q) begin
         unique case (rd_idx)
            `OXR_IDX_CHIP_CONTROL: avs_rd_d = {24'h000000, chip_control_q};
            `OXR_IDX_RAM_PAGE_HIGH: avs_rd_d = {24'h000000, page_q};
            `OXR_IDX_TIMED_ACCESS: avs_rd_d = {29'h0000000, ta_win_q};
            `OXR_IDX_PORT_ZERO: avs_rd_d = i_ext_code_exec ? 32'h0 : {24'h0, p0_latch_q};
            `OXR_IDX_PORT_TWO: avs_rd_d = i_ext_code_exec ? 32'h0 : {24'h0, p2_latch_q};
            default: avs_rd_d = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         chip_control_q <= `OXR_CHIP_CONTROL_RST;
         page_q <= 8'h00;
         p0_latch_q <= `OXR_PORT_RST;
         p2_latch_q <= `OXR_PORT_RST;
         ta_armed_q <= 1'b0;
         ta_win_q <= 3'h0;
         rack_q <= 1'b0;
         avs_rd_q <= 32'h0000_0000;
      end else begin
         chip_control_q <= chip_control_d;
         page_q <= page_d;
         p0_latch_q <= p0_latch_d;
         p2_latch_q <= p2_latch_d;
         ta_armed_q <= ta_armed_d;
         ta_win_q <= ta_win_d;
         rack_q <= rack_d;
         avs_rd_q <= avs_rd_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   a_reset_enable: assert property (@(posedge i_clk)
      i_rst |=> (enable && page_q == 8'h00)) else $error("reset values wrong");
   a_ram_quiet: assert property (@(posedge i_clk) disable iff (i_rst)
      (accept && ram_hit) |=> (o_pins.rd_n && o_pins.wr_n && !o_pins.ale && o_done))
      else $error("bus activity on RAM hit");
   a_index_hit: assert property (@(posedge i_clk) disable iff (i_rst)
      (accept && enable && i_req.op == OXR_OP_INDEX && !i_req.stack) |=> state_q == IDLE)
      else $error("indexed move left chip");
   a_data_pointer_high: assert property (@(posedge i_clk) disable iff (i_rst)
      (accept && i_req.op == OXR_OP_DATA_POINTER && i_req.data_pointer > `OXR_RAM_TOP)
      |=> state_q == EXT_ADDR ##1 state_q == EXT_STROBE) else $error("high pointer not external");
   a_ta_guard: assert property (@(posedge i_clk) disable iff (i_rst)
      (ta_win_q == 3'h0) |=> $stable(chip_control_q)) else $error("control changed unlocked");
   a_stack_ram: assert property (@(posedge i_clk) disable iff (i_rst)
      (accept && i_req.stack) |-> !ram_we ##1 !o_done) else $error("stack hit RAM");
   a_port_lock: assert property (@(posedge i_clk) disable iff (i_rst)
      i_ext_code_exec |=> ($stable(p0_latch_q) && $stable(p2_latch_q)))
      else $error("port latch changed");
   a_addr_phase: assert property (@(posedge i_clk) disable iff (i_rst)
      (state_q == EXT_ADDR) |-> (o_pins.p0_out == addr_q[7:0] && o_pins.p0_oe == 8'hff
      && o_pins.ale)) else $error("low address missing");
   a_high_addr: assert property (@(posedge i_clk) disable iff (i_rst)
      (state_q == EXT_STROBE) |-> (o_pins.p2_out == addr_q[15:8] && o_pins.p2_oe == 8'hff))
      else $error("high address missing");
   a_bus_length: assert property (@(posedge i_clk) disable iff (i_rst)
      $rose(state_q == EXT_STROBE) |-> (state_q == EXT_STROBE)[*4] ##1 o_done)
      else $error("strobe length wrong");
   a_ram_readback: assert property (@(posedge i_clk) disable iff (i_rst)
      (ram_we) |=> ram_q[$past(ram_addr)] == $past(i_req.wdata)) else $error("RAM store lost");
endmodule
`default_nettype wire

// [tb/oxr_ext_mem.sv]
// Purpose: external data memory on the multiplexed port bus
// Assumes: address latched while ale is high, data on port zero
// Notes: a released bus shows the inverse of its last level
`timescale 1ns/10ps
`default_nettype none
module oxr_ext_mem
   import oxr_pkg::*;
(
   input wire logic i_clk,
   input wire oxr_pins_t i_pins,
   output logic [7:0] o_p0
);
   logic [7:0] mem [65536];
   logic [15:0] addr_q = 16'h0000;
   logic [7:0] last_q = 8'h00;
   ////////////////////////////////////////
   // Known contents, so off-chip reads can be predicted
   initial begin
      for (int i = 0; i < 65536; i++) begin
         mem[i] = i[7:0] ^ i[15:8];
      end
   end
   // Address latch and write capture
   always @(posedge i_clk) begin
      if (i_pins.ale) begin
         addr_q <= {i_pins.p2_out, i_pins.p0_out};
      end
      if (!i_pins.wr_n) begin
         mem[addr_q] <= i_pins.p0_out;
      end
      last_q <= o_p0;
   end
   // Released bus toggles, so a stale value never passes for data
   assign o_p0 = !i_pins.rd_n ? mem[addr_q] : ~last_q;
endmodule
`default_nettype wire

// [tb/onchip_auxiliary_ram_with_external_decode_test.sv]
// Purpose: self-checking bench of the auxiliary RAM decode
// Assumes: external memory model on the port bus
// Notes: outputs sampled at the falling edge, inputs change after rising
`timescale 1ns/10ps
`default_nettype none
module onchip_auxiliary_ram_with_external_decode_test;
   import oxr_pkg::*;
   typedef struct packed {
      oxr_op_t op; logic wr; logic stk; logic [15:0] dp; logic [7:0] ix;
      logic [7:0] wd; logic ext; logic [7:0] rd;
   } oxr_row_t;
   logic i_clk = 1'b0;
   logic i_rst = 1'b1;
   logic i_req_valid = 1'b0;
   oxr_req_t i_req = '0;
   logic i_ext_code_exec = 1'b0;
   logic [9:0] i_avs_address = 10'h000;
   logic i_avs_read = 1'b0;
   logic i_avs_write = 1'b0;
   logic [31:0] i_avs_writedata = 32'h0;
   logic o_req_ready;
   logic o_done;
   logic [7:0] o_rdata;
   oxr_pins_t o_pins;
   logic [31:0] o_avs_readdata;
   logic o_avs_waitrequest;
   logic [7:0] mem_p0;
   logic [7:0] p0_pin;
   logic s_wait, s_rdy, s_done, ext_seen;
   logic [7:0] s_rdata;
   logic [31:0] s_rdd, got;
   int n_fail = 0;
   int checks = 0;
   oxr_row_t rows [11] = '{
      '{OXR_OP_DATA_POINTER, 1'b1, 1'b0, 16'h0123, 8'h00, 8'h5b, 1'b0, 8'h00},
      '{OXR_OP_DATA_POINTER, 1'b0, 1'b0, 16'h0123, 8'h00, 8'h00, 1'b0, 8'h5b},
      '{OXR_OP_INDEX, 1'b0, 1'b0, 16'h0000, 8'h23, 8'h00, 1'b0, 8'h5b},
      '{OXR_OP_INDEX, 1'b1, 1'b0, 16'h0000, 8'hff, 8'ha1, 1'b0, 8'h00},
      '{OXR_OP_DATA_POINTER, 1'b0, 1'b0, 16'h01ff, 8'h00, 8'h00, 1'b0, 8'ha1},
      '{OXR_OP_DATA_POINTER, 1'b1, 1'b0, 16'h03ff, 8'h00, 8'h3c, 1'b0, 8'h00},
      '{OXR_OP_DATA_POINTER, 1'b0, 1'b0, 16'h03ff, 8'h00, 8'h00, 1'b0, 8'h3c},
      '{OXR_OP_DATA_POINTER, 1'b1, 1'b0, 16'h0400, 8'h00, 8'hc3, 1'b1, 8'h00},
      '{OXR_OP_DATA_POINTER, 1'b0, 1'b0, 16'h0400, 8'h00, 8'h00, 1'b1, 8'hc3},
      '{OXR_OP_CODE, 1'b0, 1'b0, 16'h0123, 8'h00, 8'h00, 1'b1, 8'h22},
      '{OXR_OP_DATA_POINTER, 1'b1, 1'b1, 16'h0010, 8'h00, 8'h77, 1'b1, 8'h00}};
   ////////////////////////////////////////
   always #10 i_clk = ~i_clk;
   // Pin level: design where it drives, the memory elsewhere
   assign p0_pin = (o_pins.p0_out & o_pins.p0_oe) | (mem_p0 & ~o_pins.p0_oe);
   oxr_auxiliary_ram_decode uut (.i_clk(i_clk), .i_rst(i_rst), .i_req_valid(i_req_valid),
      .i_req(i_req), .o_req_ready(o_req_ready), .o_done(o_done), .o_rdata(o_rdata),
      .i_ext_code_exec(i_ext_code_exec), .i_p0_in(p0_pin), .o_pins(o_pins),
      .i_avs_address(i_avs_address), .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
      .i_avs_writedata(i_avs_writedata), .o_avs_readdata(o_avs_readdata),
      .o_avs_waitrequest(o_avs_waitrequest));
   oxr_ext_mem mem (.i_clk(i_clk), .i_pins(o_pins), .o_p0(mem_p0));
   // Mid-cycle sampling; any bus activity is remembered
   always @(negedge i_clk) begin
      s_wait = o_avs_waitrequest;
      s_rdy = o_req_ready;
      s_done = o_done;
      s_rdata = o_rdata;
      s_rdd = o_avs_readdata;
      if (o_pins.ale || !o_pins.rd_n || !o_pins.wr_n || |o_pins.p0_oe || |o_pins.p2_oe) begin
         ext_seen = 1'b1;
      end
   end
   ////////////////////////////////////////
   task finish_test();
      $display("checks %0d n_fail %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   task chk(input logic [31:0] g, input logic [31:0] e);
      checks++;
      if (g !== e) begin
         n_fail++;
         $display("mismatch at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   task tmo();
      n_fail++;
      $display("mismatch at %0t: wait ran out", $time);
      finish_test();
   endtask
   // Register access; keep leaves the strobe up for a back-to-back write
   task av(input logic wr, input logic [9:0] a, input logic [7:0] d, input logic keep);
      int k;
      k = 0;
      i_avs_address <= a;
      i_avs_write <= wr;
      i_avs_read <= !wr;
      i_avs_writedata <= {24'h0, d};
      do begin
         @(posedge i_clk);
         k++;
      end while (s_wait && k < 20);
      if (s_wait) tmo();
      got = s_rdd;
      if (!keep) begin
         i_avs_write <= 1'b0;
         i_avs_read <= 1'b0;
         @(posedge i_clk);
      end
   endtask
   // One move from the core, checked for bus activity and read byte
   task mv(input oxr_row_t r);
      int k;
      k = 0;
      i_req_valid <= 1'b1;
      i_req <= '{op: r.op, write: r.wr, stack: r.stk, data_pointer: r.dp, index: r.ix, wdata: r.wd};
      do begin
         @(posedge i_clk);
         k++;
      end while (!s_rdy && k < 20);
      if (!s_rdy) tmo();
      i_req_valid <= 1'b0;
      ext_seen = 1'b0;
      k = 0;
      do begin
         @(posedge i_clk);
         k++;
      end while (!s_done && k < 20);
      if (!s_done) tmo();
      chk({31'h0, ext_seen}, {31'h0, r.ext});
      if (!r.wr) chk({24'h0, s_rdata}, {24'h0, r.rd});
   endtask
   ////////////////////////////////////////
   initial begin
      repeat (5) @(posedge i_clk);
      i_rst <= 1'b0;
      @(posedge i_clk);
      av(1'b0, 10'h27c, 8'h00, 1'b0);
      chk(got, 32'h10);
      av(1'b0, 10'h284, 8'h00, 1'b0);
      chk(got, 32'h0);
      av(1'b1, 10'h004, 8'h5a, 1'b0);
      av(1'b0, 10'h004, 8'h00, 1'b0);
      chk(got, 32'h0);
      av(1'b1, 10'h284, 8'hfd, 1'b0);
      av(1'b0, 10'h284, 8'h00, 1'b0);
      chk(got, 32'h1);
      foreach (rows[i]) mv(rows[i]);
      chk({24'h0, mem.mem[16'h0400]}, 32'hc3);
      chk({24'h0, mem.mem[16'h0010]}, 32'h77);
      av(1'b1, 10'h27c, 8'h00, 1'b0);
      av(1'b0, 10'h27c, 8'h00, 1'b0);
      chk(got, 32'h10);
      av(1'b1, 10'h31c, 8'haa, 1'b1);
      av(1'b1, 10'h31c, 8'h55, 1'b1);
      av(1'b1, 10'h27c, 8'h00, 1'b0);
      av(1'b0, 10'h27c, 8'h00, 1'b0);
      chk(got, 32'h0);
      mv(oxr_row_t'{OXR_OP_DATA_POINTER, 1'b0, 1'b0, 16'h0123, 8'h00, 8'h00, 1'b1, 8'h22});
      mv(oxr_row_t'{OXR_OP_INDEX, 1'b0, 1'b0, 16'h0000, 8'h23, 8'h00, 1'b1, 8'hdc});
      i_ext_code_exec <= 1'b1;
      av(1'b1, 10'h200, 8'h12, 1'b0);
      av(1'b1, 10'h280, 8'h34, 1'b0);
      av(1'b0, 10'h200, 8'h00, 1'b0);
      chk(got, 32'h0);
      i_ext_code_exec <= 1'b0;
      // Blocked writes must have left the reset latch values
      av(1'b0, 10'h200, 8'h00, 1'b0);
      chk(got, 32'hff);
      av(1'b0, 10'h280, 8'h00, 1'b0);
      chk(got, 32'hff);
      av(1'b1, 10'h200, 8'h12, 1'b0);
      av(1'b0, 10'h200, 8'h00, 1'b0);
      chk(got, 32'h12);
      i_rst <= 1'b1;
      repeat (2) @(posedge i_clk);
      i_rst <= 1'b0;
      @(posedge i_clk);
      av(1'b0, 10'h27c, 8'h00, 1'b0);
      chk(got, 32'h10);
      av(1'b0, 10'h284, 8'h00, 1'b0);
      chk(got, 32'h0);
      finish_test();
   end
endmodule
`default_nettype wire
